// file: clock_modulator.sv
`timescale 1ns/1ps
`default_nettype none
`include "thermal_cfg.svh"
module clock_modulator
  import thermal_pkg::*;
(
  // Clock and reset
  input  wire logic     clock_i,
  input  wire logic     rst_i,
  // Duty request
  input  wire mod_cfg_t cfg_i,
  // Core clock gate
  output logic          clk_run_o
);
  logic [`CNT_W-1:0] slot_cnt_r;
  logic [`CNT_W-1:0] slot_cnt_nxt;
  logic [2:0]        slot_r;
  logic [2:0]        slot_nxt;
  logic              run_r;
  logic              run_nxt;

  // Eight slots per period; slot n runs while n < duty
  always_comb begin
    slot_cnt_nxt = slot_cnt_r;
    slot_nxt     = slot_r;
    if (!cfg_i.enable) begin
      slot_cnt_nxt = '0;
      slot_nxt     = '0;
    end else if (slot_cnt_r == `CNT_W'(`MOD_SLOT_CYC - 1)) begin
      slot_cnt_nxt = '0;
      slot_nxt     = slot_r + 3'h1;
    end else begin
      slot_cnt_nxt = slot_cnt_r + `CNT_W'(1);
    end
    run_nxt = !cfg_i.enable || (slot_nxt < cfg_i.duty);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      slot_cnt_r <= '0;
      slot_r     <= '0;
      run_r      <= 1'b1;
    end else begin
      slot_cnt_r <= slot_cnt_nxt;
      slot_r     <= slot_nxt;
      run_r      <= run_nxt;
    end
  end

  assign clk_run_o = run_r;
endmodule
`default_nettype wire

// file: hyst_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "thermal_cfg.svh"
module hyst_timer (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // Restart while hot
  input  wire logic hot_i,
  // Cool long enough
  output logic      expired_o
);
  logic [`HYST_W-1:0] cnt_r;
  logic [`HYST_W-1:0] cnt_nxt;

  always_comb begin
    if (hot_i)
      cnt_nxt = '0;
    else if (cnt_r != `HYST_W'(`HYST_CYC))
      cnt_nxt = cnt_r + `HYST_W'(1);
    else
      cnt_nxt = cnt_r;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign expired_o = !hot_i && (cnt_r == `HYST_W'(`HYST_CYC));
endmodule
`default_nettype wire

// file: tb_thermal_throttle_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "thermal_cfg.svh"
module tb_thermal_throttle_control;
  import thermal_pkg::*;
  logic       clock_i = 1'b0;
  logic       rst_i   = 1'b1;
  logic [1:0] core_hot = 2'h0;
  logic       board_hot = 1'b0;
  logic       gate_en = 1'b0;
  logic       fv_en   = 1'b0;
  logic       irq_edge = 1'b0;
  logic [4:0] ctl     = 5'h00;
  logic [1:0] irq_sel = 2'h0;
  wire logic  line_n, dat, oe, svc, pend, airq, run, blk, fv_act, gate_act;
  op_point_t  op;
  logic [7:0] big_steps;
  int         n_fail = 0;
  int         num_checks = 0;
  int         n_airq = 0;

  always #20 clock_i = ~clock_i;
  always @(posedge clock_i) if (airq === 1'b1) n_airq++;

  thermal_throttle_control u_thermal_throttle_control (
    .clock_i(clock_i), .rst_i(rst_i), .core_hot_i(core_hot),
    .thermal_alarm_n_i(line_n), .thermal_alarm_n_o(dat), .thermal_alarm_n_oe_o(oe),
    .gate_throttle_en_i(gate_en), .freq_voltage_throttle_mode_i(fv_en),
    .clock_modulation_control_reg_i(ctl), .ratio_status_reg_i(8'h0c),
    .nominal_vsc_i(6'h14), .low_point_i({8'h06, 6'h10}), .alarm_irq_sel_i(irq_sel),
    .irq_edge_i(irq_edge), .irq_service_o(svc), .irq_pending_o(pend),
    .alarm_irq_o(airq), .core_clk_run_o(run), .bus_block_o(blk), .snoop_en_o(),
    .op_point_o(op), .tcc_gate_active_o(gate_act), .fv_active_o(fv_act));

  thermal_partner u_thermal_partner (
    .clock_i(clock_i), .board_hot_i(board_hot), .dev_oe_i(oe), .dev_data_i(dat),
    .alarm_line_n_o(line_n), .follow_i(fv_act), .op_point_i(op),
    .big_steps_o(big_steps));

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // A wait that ran out ends the run here
  task automatic expect_done(input string what, input logic ok);
    chk(what, 1, ok);
    if (ok !== 1'b1) give_verdict();
  endtask

  // Any 56 cycles hold exactly one modulation period
  task automatic run_cnt(output int n);
    n = 0;
    repeat (56) begin
      @(negedge clock_i);
      n += (run === 1'b1) ? 1 : 0;
    end
  endtask

  initial begin
    int n;
    int i;
    tick(8);
    rst_i <= 1'b0;
    tick(3);
    @(negedge clock_i);
    chk("op_point", {8'h0c, 6'h14}, op);
    for (int s = 1; s < 4; s++) begin
      tick(1);
      irq_sel <= s[1:0];
      n = n_airq;
      core_hot <= 2'h2;
      tick(4);
      @(negedge clock_i);
      chk("alarm_oe", 1, oe);
      chk("gate_act", 0, gate_act);
      tick(1);
      core_hot <= 2'h0;
      tick(4);
      chk("alarm_irq", (s == 3) ? 2 : 1, n_airq - n);
    end
    $display("test alarm done");
    fv_en <= 1'b1;
    for (int d = 0; d < 8; d++) begin
      tick(1);
      ctl <= {1'b1, d[2:0], 1'b0};
      tick(60);
      run_cnt(n);
      chk("run_duty", (d == 0 ? `FACTORY_DUTY : d) * `MOD_SLOT_CYC, n);
    end
    chk("fv_forced", 0, fv_act);
    $display("test forced done");
    tick(1);
    fv_en <= 1'b0;
    gate_en <= 1'b1;
    ctl <= 5'h1e;
    core_hot <= 2'h1;
    tick(60);
    run_cnt(n);
    chk("gate_duty", `FACTORY_DUTY * `MOD_SLOT_CYC, n);
    chk("gate_act", 1, gate_act);
    // Look at the run level where it has settled, not on the edge that launches it
    for (i = 0; i < 60 && run !== 1'b0; i++) @(negedge clock_i);
    expect_done("run_off", run === 1'b0);
    tick(1);
    irq_edge <= 1'b1;
    tick(1);
    irq_edge <= 1'b0;
    @(negedge clock_i);
    chk("irq_gated", 2'h2, {pend, svc});
    for (i = 0; i < 60 && svc !== 1'b1; i++) @(negedge clock_i);
    expect_done("irq_service", svc);
    tick(1);
    ctl <= 5'h00;
    core_hot <= 2'h0;
    tick(2400);
    @(negedge clock_i);
    chk("gate_hold", 1, gate_act);
    for (i = 0; i < 300 && gate_act !== 1'b0; i++) @(negedge clock_i);
    expect_done("gate_release", !gate_act);
    $display("test gating done");
    tick(1);
    board_hot <= 1'b1;
    tick(3);
    @(negedge clock_i);
    chk("ext_gate", 1, gate_act);
    chk("ext_oe", 0, oe);
    tick(1);
    board_hot <= 1'b0;
    for (i = 0; i < 2700 && gate_act !== 1'b0; i++) @(negedge clock_i);
    expect_done("ext_release", !gate_act);
    $display("test external done");
    tick(1);
    gate_en <= 1'b0;
    fv_en <= 1'b1;
    core_hot <= 2'h1;
    tick(2);
    @(negedge clock_i);
    chk("low_ratio", 8'h06, op.ratio);
    chk("bus_block", 1, blk);
    tick(1);
    irq_edge <= 1'b1;
    tick(1);
    irq_edge <= 1'b0;
    tick(5);
    @(negedge clock_i);
    chk("irq_held", 2'h2, {pend, svc});
    for (i = 0; i < 400 && op.vsc !== 6'h10; i++) @(negedge clock_i);
    expect_done("vsc_low", op.vsc === 6'h10);
    chk("irq_after", 0, pend);
    tick(1);
    core_hot <= 2'h0;
    for (i = 0; i < 3200 && fv_act !== 1'b0; i++) @(negedge clock_i);
    expect_done("fv_release", !fv_act);
    chk("op_back", {8'h0c, 6'h14}, op);
    chk("big_steps", 0, big_steps);
    $display("test freq voltage done");
    give_verdict();
  end
endmodule
`default_nettype wire

// file: thermal_cfg.svh
// Behaviour
// - At maximum temperature engage throttle circuit; gating mode stops and restarts core clocks
// - Trip threshold is fixed in hardware; software cannot set or read it
// - While gating, snooping continues; interrupts latched, serviced only while clocks run
// - Gating alternates off and on at fixed duty; off intervals within 3.0 us
// - Gating releases only when cool and hysteresis timer has expired
// - Temperature-triggered gating duty is fixed at manufacture, not alterable
// - Frequency/voltage mode first drops to lower bus multiplier, about 5 us
// - During frequency change block bus traffic and hold edge interrupts pending
// - After lower frequency engages, step voltage code one entry per step to target
// - On release after hysteresis restore voltage code first, then normal frequency
// - Normal point uses ratio status register ratio and nominal voltage code
// - Hot signal asserted on high temperature whatever throttle modes are enabled
// - Software forcing never activates frequency/voltage throttling, only clock gating
// - Forcing bit set starts clock modulation immediately regardless of temperature
// - Forced mode takes on-duty from bits 3:1, 12.5% to 87.5% steps
// - Forced and temperature throttle together use the factory duty cycle
// - Optional interrupt on hot signal assertion, deassertion or both
// - Hot signal driven active when either core reaches its maximum temperature
// - External hot input throttles both cores, if enabled, until released
`ifndef THERMAL_CFG_SVH
`define THERMAL_CFG_SVH

`define CLK_MHZ         25
`define FACTORY_DUTY    3'h4
`define MOD_SLOT_NS     300
`define MOD_SLOT_CYC    (((`MOD_SLOT_NS * `CLK_MHZ) / 1000) < 1 ? 1 : ((`MOD_SLOT_NS * `CLK_MHZ) / 1000))
`define FREQ_SW_NS      5000
`define FREQ_SW_CYC     ((`FREQ_SW_NS * `CLK_MHZ) / 1000)
`define VSTEP_NS        1000
`define VSTEP_CYC       ((`VSTEP_NS * `CLK_MHZ) / 1000)
`define HYST_US         100
`define HYST_CYC        (`HYST_US * `CLK_MHZ)
`define CNT_W           8
`define HYST_W          12
`define RATIO_W         8
`define VSC_W           6
`define CTL_FORCE_BIT   4
`define CTL_DUTY_HI     3
`define CTL_DUTY_LO     1
`define IRQ_SEL_ASSERT  0
`define IRQ_SEL_DEASSERT 1

`endif

// file: thermal_partner.sv
`timescale 1ns/1ps
`default_nettype none
`include "thermal_cfg.svh"
module thermal_partner
  import thermal_pkg::*;
(
  // Clock
  input  wire logic      clock_i,
  // Hot line parties
  input  wire logic      board_hot_i,
  input  wire logic      dev_oe_i,
  input  wire logic      dev_data_i,
  output logic           alarm_line_n_o,
  // Regulator code input
  input  wire logic      follow_i,
  input  wire op_point_t op_point_i,
  output logic [7:0]     big_steps_o
);
  logic [`VSC_W-1:0] vsc_r = 6'h00;
  initial big_steps_o = 8'h00;
  // Pulled up; board or device may pull it low
  assign alarm_line_n_o = !(board_hot_i || (dev_oe_i && !dev_data_i));
  // Takes every code on the fly; jumps wider than one entry are counted while follow_i is high
  always @(posedge clock_i) begin
    if (follow_i && op_point_i.vsc != vsc_r && op_point_i.vsc != vsc_r + 6'h01 &&
        op_point_i.vsc + 6'h01 != vsc_r)
      big_steps_o <= big_steps_o + 8'h01;
    vsc_r <= op_point_i.vsc;
  end
endmodule
`default_nettype wire

// file: thermal_pkg.sv
`include "thermal_cfg.svh"
package thermal_pkg;
  typedef struct packed {
    logic [`RATIO_W-1:0] ratio;
    logic [`VSC_W-1:0]   vsc;
  } op_point_t;

  typedef struct packed {
    logic       enable;
    logic [2:0] duty;
  } mod_cfg_t;

  typedef enum logic [5:0] {
    FV_NORMAL  = 6'h01,
    FV_FREQ_DN = 6'h02,
    FV_VOLT_DN = 6'h04,
    FV_LOW     = 6'h08,
    FV_VOLT_UP = 6'h10,
    FV_FREQ_UP = 6'h20
  } fv_state_t;
endpackage

// file: thermal_throttle_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "thermal_cfg.svh"
module thermal_throttle_control
  import thermal_pkg::*;
(
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  // Per-core comparators against the fused trip point
  input  wire logic [1:0]          core_hot_i,
  // Open-drain hot line
  input  wire logic                thermal_alarm_n_i,
  output logic                     thermal_alarm_n_o,
  output logic                     thermal_alarm_n_oe_o,
  // Configuration
  input  wire logic                gate_throttle_en_i,
  input  wire logic                freq_voltage_throttle_mode_i,
  input  wire logic [4:0]          clock_modulation_control_reg_i,
  input  wire logic [`RATIO_W-1:0] ratio_status_reg_i,
  input  wire logic [`VSC_W-1:0]   nominal_vsc_i,
  input  wire op_point_t           low_point_i,
  input  wire logic [1:0]          alarm_irq_sel_i,
  // Interrupt intake and service
  input  wire logic                irq_edge_i,
  output logic                     irq_service_o,
  output logic                     irq_pending_o,
  output logic                     alarm_irq_o,
  // Core and bus control
  output logic                     core_clk_run_o,
  output logic                     bus_block_o,
  output logic                     snoop_en_o,
  output op_point_t                op_point_o,
  output logic                     tcc_gate_active_o,
  output logic                     fv_active_o
);
  logic      own_hot;
  logic      ext_hot;
  logic      hot_any;
  logic      hyst_done;
  logic      force_mod;
  logic [2:0] force_duty;
  mod_cfg_t  mod_cfg;
  logic      clk_run;

  // Pin state
  logic      hot_prev_r;
  logic      hot_prev_nxt;
  logic      alarm_irq_r;
  logic      alarm_irq_nxt;

  // Gating throttle
  logic      gate_r;
  logic      gate_nxt;

  // Frequency/voltage point
  fv_state_t          state_r;
  fv_state_t          state_nxt;
  logic [`CNT_W-1:0]  cnt_r;
  logic [`CNT_W-1:0]  cnt_nxt;
  op_point_t          point_r;
  op_point_t          point_nxt;

  // Interrupt latch
  logic      pend_r;
  logic      pend_nxt;
  logic      serve_r;
  logic      serve_nxt;

  // Own comparators only; the threshold has no software path
  assign own_hot = |core_hot_i;
  // Line is low when anyone pulls it; the own pull does not count as external
  assign ext_hot = !thermal_alarm_n_i && !own_hot;
  assign hot_any = own_hot || ext_hot;

  // Drive low whenever a core is hot, whatever modes are enabled
  assign thermal_alarm_n_o    = 1'b0;
  assign thermal_alarm_n_oe_o = own_hot;

  assign force_mod  = clock_modulation_control_reg_i[`CTL_FORCE_BIT];
  assign force_duty = clock_modulation_control_reg_i[`CTL_DUTY_HI:`CTL_DUTY_LO];

  hyst_timer u_hyst (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .hot_i     (hot_any),
    .expired_o (hyst_done)
  );

  // Alarm edge interrupt request
  always_comb begin
    hot_prev_nxt  = hot_any;
    alarm_irq_nxt = (hot_any && !hot_prev_r && alarm_irq_sel_i[`IRQ_SEL_ASSERT]) ||
                    (!hot_any && hot_prev_r && alarm_irq_sel_i[`IRQ_SEL_DEASSERT]);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hot_prev_r  <= 1'b0;
      alarm_irq_r <= 1'b0;
    end else begin
      hot_prev_r  <= hot_prev_nxt;
      alarm_irq_r <= alarm_irq_nxt;
    end
  end

  // Gating throttle: engage on heat, hold until cool plus hysteresis
  always_comb begin
    gate_nxt = gate_r;
    if (!gate_throttle_en_i)
      gate_nxt = 1'b0;
    else if (hot_any)
      gate_nxt = 1'b1;
    else if (hyst_done)
      gate_nxt = 1'b0;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i)
      gate_r <= 1'b0;
    else
      gate_r <= gate_nxt;
  end

  // Factory duty wins over the forced one; duty 0 is reserved, factory used
  always_comb begin
    mod_cfg.enable = gate_r || force_mod;
    if (gate_r || force_duty == 3'h0)
      mod_cfg.duty = `FACTORY_DUTY;
    else
      mod_cfg.duty = force_duty;
  end

  clock_modulator u_mod (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .cfg_i     (mod_cfg),
    .clk_run_o (clk_run)
  );

  // Frequency/voltage sequencer; only temperature starts it, never forcing
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    point_nxt = point_r;
    case (state_r)
      FV_NORMAL: begin
        point_nxt.ratio = ratio_status_reg_i;
        point_nxt.vsc   = nominal_vsc_i;
        if (freq_voltage_throttle_mode_i && hot_any) begin
          state_nxt       = FV_FREQ_DN;
          point_nxt.ratio = low_point_i.ratio;
          cnt_nxt         = '0;
        end
      end
      FV_FREQ_DN: begin
        if (cnt_r == `CNT_W'(`FREQ_SW_CYC - 1)) begin
          state_nxt = FV_VOLT_DN;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r + `CNT_W'(1);
        end
      end
      FV_VOLT_DN: begin
        if (point_r.vsc == low_point_i.vsc) begin
          state_nxt = FV_LOW;
        end else if (cnt_r == `CNT_W'(`VSTEP_CYC - 1)) begin
          cnt_nxt = '0;
          if (point_r.vsc < low_point_i.vsc)
            point_nxt.vsc = point_r.vsc + `VSC_W'(1);
          else
            point_nxt.vsc = point_r.vsc - `VSC_W'(1);
        end else begin
          cnt_nxt = cnt_r + `CNT_W'(1);
        end
      end
      FV_LOW: begin
        cnt_nxt = '0;
        if (!hot_any && hyst_done)
          state_nxt = FV_VOLT_UP;
      end
      FV_VOLT_UP: begin
        if (point_r.vsc == nominal_vsc_i) begin
          state_nxt       = FV_FREQ_UP;
          point_nxt.ratio = ratio_status_reg_i;
          cnt_nxt         = '0;
        end else if (cnt_r == `CNT_W'(`VSTEP_CYC - 1)) begin
          cnt_nxt = '0;
          if (point_r.vsc < nominal_vsc_i)
            point_nxt.vsc = point_r.vsc + `VSC_W'(1);
          else
            point_nxt.vsc = point_r.vsc - `VSC_W'(1);
        end else begin
          cnt_nxt = cnt_r + `CNT_W'(1);
        end
      end
      FV_FREQ_UP: begin
        if (cnt_r == `CNT_W'(`FREQ_SW_CYC - 1)) begin
          state_nxt = FV_NORMAL;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r + `CNT_W'(1);
        end
      end
      default: begin
        state_nxt = FV_NORMAL;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= FV_NORMAL;
      cnt_r   <= '0;
      point_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      point_r <= point_nxt;
    end
  end

  // Bus frozen only while the multiplier moves
  assign bus_block_o = (state_r == FV_FREQ_DN) || (state_r == FV_FREQ_UP);
  // Snooping is unaffected by clock gating
  assign snoop_en_o  = !bus_block_o;

  // Interrupt latch; a new edge wins over the service clear
  always_comb begin
    serve_nxt = pend_r && clk_run && !bus_block_o;
    pend_nxt  = (pend_r && !serve_nxt) || irq_edge_i;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pend_r  <= 1'b0;
      serve_r <= 1'b0;
    end else begin
      pend_r  <= pend_nxt;
      serve_r <= serve_nxt;
    end
  end

  assign irq_service_o     = serve_r;
  assign irq_pending_o     = pend_r;
  assign alarm_irq_o       = alarm_irq_r;
  assign core_clk_run_o    = clk_run;
  assign op_point_o        = point_r;
  assign tcc_gate_active_o = gate_r;
  assign fv_active_o       = (state_r != FV_NORMAL);
endmodule
`default_nettype wire

// file: thermal_throttle_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "thermal_cfg.svh"
module thermal_throttle_control_chk
  import thermal_pkg::*;
(
  // Clock and reset
  input wire logic                clock_i,
  input wire logic                rst_i,
  // Hot sources and configuration
  input wire logic [1:0]          core_hot_i,
  input wire logic                thermal_alarm_n_i,
  input wire logic                gate_throttle_en_i,
  input wire logic                freq_voltage_throttle_mode_i,
  input wire logic [`RATIO_W-1:0] ratio_status_reg_i,
  input wire logic [`VSC_W-1:0]   nominal_vsc_i,
  input wire op_point_t           low_point_i,
  input wire logic [1:0]          alarm_irq_sel_i,
  // Observed outputs
  input wire logic                thermal_alarm_n_oe_o,
  input wire logic                irq_service_o,
  input wire logic                irq_pending_o,
  input wire logic                alarm_irq_o,
  input wire logic                core_clk_run_o,
  input wire logic                bus_block_o,
  input wire logic                snoop_en_o,
  input wire op_point_t           op_point_o,
  input wire logic                tcc_gate_active_o,
  input wire logic                fv_active_o
);
  logic [7:0] blk_len_r;
  logic [7:0] blk_len_nxt;
  logic       hot_any;

  assign hot_any = |core_hot_i || !thermal_alarm_n_i;
  // Length of the current bus block, for the frequency change time
  always_comb blk_len_nxt = bus_block_o ? blk_len_r + 8'h01 : 8'h00;
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i) blk_len_r <= 8'h00;
    else blk_len_r <= blk_len_nxt;

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_ALARM_OE: assert property (thermal_alarm_n_oe_o == |core_hot_i)
    else $error("alarm drive does not follow core hot");
  AST_GATE_ON: assert property (|core_hot_i && gate_throttle_en_i |=> tcc_gate_active_o)
    else $error("gating not engaged when hot");
  AST_SNOOP: assert property (snoop_en_o == !bus_block_o)
    else $error("snoop not running outside bus block");
  AST_SVC_GO: assert property (irq_pending_o && core_clk_run_o && !bus_block_o |=> irq_service_o)
    else $error("pending interrupt not serviced");
  AST_SVC_HOLD: assert property (irq_service_o |-> $past(core_clk_run_o) && !$past(bus_block_o))
    else $error("interrupt serviced while clocks stopped or bus blocked");
  AST_BLK_LEN: assert property ($fell(bus_block_o) |-> blk_len_r == `FREQ_SW_CYC)
    else $error("frequency change length wrong");
  AST_FREQ_FIRST: assert property ($rose(fv_active_o) |-> bus_block_o &&
      op_point_o.ratio == low_point_i.ratio && $stable(op_point_o.vsc))
    else $error("throttle entry did not change ratio first");
  AST_VSC_STEP: assert property (fv_active_o && $changed(op_point_o.vsc) |-> !bus_block_o &&
      (op_point_o.vsc == $past(op_point_o.vsc) + 6'h01 ||
       op_point_o.vsc + 6'h01 == $past(op_point_o.vsc)))
    else $error("voltage code step not one entry");
  AST_UP_ORDER: assert property ($rose(bus_block_o) && $past(fv_active_o) |->
      op_point_o.vsc == nominal_vsc_i)
    else $error("ratio restored before voltage code");
  AST_NORMAL_PT: assert property (!fv_active_o && !$past(fv_active_o) && !$past(rst_i) |->
      op_point_o == {$past(ratio_status_reg_i), $past(nominal_vsc_i)})
    else $error("normal operating point wrong");
  AST_FV_CAUSE: assert property ($rose(fv_active_o) |->
      $past(freq_voltage_throttle_mode_i) && $past(hot_any))
    else $error("frequency throttle entered without heat");
  AST_ALARM_IRQ: assert property ($rose(hot_any) && alarm_irq_sel_i[0] |=> alarm_irq_o)
    else $error("alarm interrupt missing on assertion");

  cover property ($rose(fv_active_o));
  cover property (irq_service_o && tcc_gate_active_o);
  cover property ($fell(tcc_gate_active_o));
endmodule
bind thermal_throttle_control thermal_throttle_control_chk u_thermal_throttle_control_chk (.*);
`default_nettype wire
